// *** hdl/flsr_ctrl.sv ***
// Suspend and resume controller for embedded erase and page program.
// Assumes the array engine raises array_halted_i once it has paused and
// array_done_i when an operation finishes; start pulses come from the
// device's command engine on the core clock.
`timescale 1ns/1ps
module flsr_ctrl #(
   parameter int SUSP_LAT_CYC = flsr_pkg::SUSP_LAT_CYC
) (
   // Core clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Serial link
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   // Array engine
   input wire logic erase_start_i,
   input wire logic prog_start_i,
   input wire logic array_done_i,
   input wire logic array_halted_i,
   output logic array_halt_o,
   // Status
   output logic operation_busy_flag_o,
   output logic erase_suspended_o,
   output logic prog_suspended_o
);
   localparam int CW = $clog2(SUSP_LAT_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(SUSP_LAT_CYC - 1);

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ERASE = 7'h02,
      ST_ES_WAIT = 7'h04,
      ST_ES_SUSP = 7'h08,
      ST_PROG = 7'h10,
      ST_PS_WAIT = 7'h20,
      ST_PS_SUSP = 7'h40
   } flsr_state_t;

   flsr_link_if lnk ();

   flsr_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic halt_q, halt_d;
   logic busy_q, busy_d;
   logic esusp_q, esusp_d;
   logic psusp_q, psusp_d;
   logic tgl_s1_q, tgl_s1_d;
   logic tgl_s2_q, tgl_s2_d;
   logic tgl_ref_q, tgl_ref_d;
   logic evt;
   logic [7:0] op;

   // ==========================================================
   // Link end
   flsr_spi_link u_link (
      .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_o(spi_miso_oe_o),
      .lnk(lnk.link)
   );

   assign lnk.busy = busy_q;

   // ==========================================================
   // Command crossing
   // The opcode is held by the link for at least eight serial clocks,
   // far longer than the three core cycles the toggle needs to arrive.
   always_comb begin
      tgl_s1_d = lnk.cmd_tgl;
      tgl_s2_d = tgl_s1_q;
      tgl_ref_d = tgl_s2_q;
   end

   always_ff @(posedge clk_i) begin
      tgl_s1_q <= tgl_s1_d;
      tgl_s2_q <= tgl_s2_d;
      tgl_ref_q <= tgl_ref_d;
   end

   // Under reset the reference follows the synchroniser, so no stale
   // toggle turns into a command at release.
   assign evt = ~srst_i & (tgl_s2_q ^ tgl_ref_q);
   assign op = lnk.opcode;

   // ==========================================================
   // Operation state
   always_comb begin
      state_d = state_q;
      cnt_d = '0;
      case (state_q)
         ST_IDLE: begin
            if (erase_start_i) begin
               state_d = ST_ERASE;
            end else if (prog_start_i) begin
               state_d = ST_PROG;
            end
         end
         ST_ERASE: begin
            if (array_done_i) begin
               state_d = ST_IDLE;
            end else if (evt && op == flsr_pkg::OP_ERASE_SUSP) begin
               state_d = ST_ES_WAIT;
            end
         end
         ST_ES_WAIT: begin
            if (array_done_i) begin
               state_d = ST_IDLE;
            end else if (array_halted_i || cnt_q == CNT_LAST) begin
               state_d = ST_ES_SUSP;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         ST_ES_SUSP: begin
            if (evt && op == flsr_pkg::OP_ERASE_RES) begin
               state_d = ST_ERASE;
            end
         end
         ST_PROG: begin
            if (array_done_i) begin
               state_d = ST_IDLE;
            end else if (evt && op == flsr_pkg::OP_PROG_SUSP) begin
               state_d = ST_PS_WAIT;
            end
         end
         ST_PS_WAIT: begin
            if (array_done_i) begin
               state_d = ST_IDLE;
            end else if (array_halted_i || cnt_q == CNT_LAST) begin
               state_d = ST_PS_SUSP;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         ST_PS_SUSP: begin
            if (evt && op == flsr_pkg::OP_PROG_RES) begin
               state_d = ST_PROG;
            end
         end
         // Any other state encoding falls back to idle
         default: state_d = ST_IDLE;
      endcase
      halt_d = (state_d == ST_ES_WAIT) || (state_d == ST_ES_SUSP) ||
               (state_d == ST_PS_WAIT) || (state_d == ST_PS_SUSP);
      busy_d = (state_d == ST_ERASE) || (state_d == ST_PROG) ||
               (state_d == ST_ES_WAIT) || (state_d == ST_PS_WAIT);
      esusp_d = (state_d == ST_ES_SUSP);
      psusp_d = (state_d == ST_PS_SUSP);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         halt_q <= 1'b0;
         busy_q <= 1'b0;
         esusp_q <= 1'b0;
         psusp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         halt_q <= halt_d;
         busy_q <= busy_d;
         esusp_q <= esusp_d;
         psusp_q <= psusp_d;
      end
   end

   assign array_halt_o = halt_q;
   assign operation_busy_flag_o = busy_q;
   assign erase_suspended_o = esusp_q;
   assign prog_suspended_o = psusp_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   chk_erase_susp_lat: assert property (
      (state_q == ST_ES_WAIT && cnt_q == CNT_LAST && !array_done_i)
      |=> (state_q == ST_ES_SUSP && !operation_busy_flag_o))
      else $error("erase suspend latency exceeded");
   chk_prog_susp_lat: assert property (
      (state_q == ST_PS_WAIT && cnt_q == CNT_LAST && !array_done_i)
      |=> (state_q == ST_PS_SUSP && !operation_busy_flag_o))
      else $error("program suspend latency exceeded");
   chk_wait_count_bound: assert property (
      (state_q == ST_ES_WAIT || state_q == ST_PS_WAIT)
      |-> (cnt_q <= CNT_LAST))
      else $error("suspend wait counter past its limit");
   chk_psusp_unit_code: assert property (
      flsr_pkg::DISC_WORD[flsr_pkg::PSUSP_UNIT_MSB:flsr_pkg::PSUSP_UNIT_LSB]
      == 2'h2)
      else $error("program suspend unit code is not 8 us");
   chk_disc_word_value: assert property (
      flsr_pkg::DISC_WORD == flsr_pkg::DISC_WORD_EXPECTED)
      else $error("discovery word value wrong");
   chk_erase_susp_halt: assert property (
      (state_q == ST_ERASE && !array_done_i && evt &&
       op == flsr_pkg::OP_ERASE_SUSP)
      |=> (array_halt_o && operation_busy_flag_o && !erase_suspended_o))
      else $error("erase suspend did not halt the array");
   chk_erase_resume: assert property (
      (state_q == ST_ES_SUSP && evt && op == flsr_pkg::OP_ERASE_RES)
      |=> (!array_halt_o && operation_busy_flag_o && !erase_suspended_o))
      else $error("erase resume did not restart erase");
   chk_prog_susp_halt: assert property (
      (state_q == ST_PROG && !array_done_i && evt &&
       op == flsr_pkg::OP_PROG_SUSP)
      |=> (array_halt_o && state_q == ST_PS_WAIT))
      else $error("program suspend did not halt the array");
   chk_prog_resume: assert property (
      (state_q == ST_PS_SUSP && evt && op == flsr_pkg::OP_PROG_RES)
      |=> (!array_halt_o && state_q == ST_PROG && !prog_suspended_o))
      else $error("program resume did not restart program");
   chk_stray_cmd_idle: assert property (
      (state_q == ST_IDLE && evt && !erase_start_i && !prog_start_i)
      |=> (state_q == ST_IDLE && !array_halt_o))
      else $error("stray suspend or resume changed state");
   chk_suspended_ready: assert property (
      (erase_suspended_o || prog_suspended_o)
      |-> (!operation_busy_flag_o && array_halt_o))
      else $error("busy still set after suspend");
endmodule : flsr_ctrl

// *** hdl/flsr_pkg.sv ***
// Constants for the suspend and resume controller of the serial flash.
// Assumes a 250 MHz core clock; the link side runs on the serial clock.
package flsr_pkg;
   // ==========================================================
   // Instruction bytes
   localparam logic [7:0] OP_ERASE_SUSP = 8'h75;
   localparam logic [7:0] OP_ERASE_RES = 8'h7a;
   localparam logic [7:0] OP_PROG_SUSP = 8'h85;
   localparam logic [7:0] OP_PROG_RES = 8'h8a;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_READ_DISC = 8'h5a;
   localparam int STAT_BUSY_BIT = 0;
   // ==========================================================
   // Discovery table suspend-timing word, field by field
   localparam logic [0:0] SR_SUPPORTED = 1'h0;
   localparam logic [1:0] ESUSP_UNIT_8US = 2'h2;
   localparam logic [4:0] ESUSP_LAT_COUNT = 5'h04;
   localparam logic [3:0] ERES_INTERVAL_COUNT = 4'h1;
   localparam logic [1:0] PSUSP_UNIT_8US = 2'h2;
   localparam logic [4:0] PSUSP_LAT_COUNT = 5'h04;
   localparam logic [3:0] PRES_INTERVAL_COUNT = 4'h1;
   localparam logic [0:0] DISC_RFU_BIT = 1'h1;
   localparam logic [3:0] ERASE_SUSP_PROHIBIT = 4'he;
   localparam logic [3:0] PROG_SUSP_PROHIBIT = 4'hc;
   localparam int PSUSP_UNIT_LSB = 18;
   localparam int PSUSP_UNIT_MSB = 19;
   localparam logic [31:0] DISC_WORD = {SR_SUPPORTED, ESUSP_UNIT_8US,
      ESUSP_LAT_COUNT, ERES_INTERVAL_COUNT, PSUSP_UNIT_8US, PSUSP_LAT_COUNT,
      PRES_INTERVAL_COUNT, DISC_RFU_BIT, ERASE_SUSP_PROHIBIT,
      PROG_SUSP_PROHIBIT};
   localparam logic [31:0] DISC_WORD_EXPECTED = 32'h4418_83ec;
   // ==========================================================
   // Discovery read framing
   localparam logic [4:0] DISC_ADDR_BITS = 5'h18;
   localparam logic [4:0] DISC_DUMMY_BITS = 5'h08;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int SUSP_LAT_NS = 40000;
   localparam int SUSP_LAT_CYC = SUSP_LAT_NS * CLK_MHZ / 1000;
endpackage : flsr_pkg

// *** hdl/flsr_link_if.sv ***
// Carrier between the serial link end and the core of the controller.
// Opcode is held stable while the toggle announces it to the core.
`timescale 1ns/1ps
interface flsr_link_if;
   logic [7:0] opcode;
   logic cmd_tgl;
   logic busy;
   modport link (output opcode, output cmd_tgl, input busy);
   modport core (input opcode, input cmd_tgl, output busy);
endinterface : flsr_link_if

// *** hdl/flsr_spi_link.sv ***
// Serial link end: shifts in instructions on the serial clock, announces
// each opcode to the core, answers status and discovery reads.
// Assumes mode 0 framing; the serial clock stands still outside frames.
`timescale 1ns/1ps
module flsr_spi_link (
   // Serial pins
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   // Core side
   flsr_link_if.link lnk
);
   typedef enum logic [5:0] {
      PH_CMD = 6'h01,
      PH_ADDR = 6'h02,
      PH_DUMMY = 6'h04,
      PH_STAT = 6'h08,
      PH_DISC = 6'h10,
      PH_SKIP = 6'h20
   } flsr_phase_t;

   flsr_phase_t phase_q, phase_d;
   logic [4:0] cnt_q, cnt_d;
   logic [6:0] sh_q, sh_d;
   // Not cleared by chip select: a reset here would fake a toggle
   logic [7:0] opc_q = 8'h00;
   logic [7:0] opc_d;
   logic tgl_q = 1'b0;
   logic tgl_d;
   logic busy_s1_q, busy_s2_q;
   logic miso_d, oe_d;

   // ==========================================================
   // Shift and phase
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q + 5'h01;
      sh_d = sh_q;
      opc_d = opc_q;
      tgl_d = tgl_q;
      case (phase_q)
         PH_CMD: begin
            sh_d = {sh_q[5:0], spi_mosi_i};
            if (cnt_q == 5'h07) begin
               opc_d = {sh_q, spi_mosi_i};
               tgl_d = ~tgl_q;
               cnt_d = 5'h00;
               if ({sh_q, spi_mosi_i} == flsr_pkg::OP_READ_STATUS) begin
                  phase_d = PH_STAT;
               end else if ({sh_q, spi_mosi_i} == flsr_pkg::OP_READ_DISC) begin
                  phase_d = PH_ADDR;
               end else begin
                  phase_d = PH_SKIP;
               end
            end
         end
         PH_ADDR: begin
            if (cnt_q == flsr_pkg::DISC_ADDR_BITS - 5'h01) begin
               cnt_d = 5'h00;
               phase_d = PH_DUMMY;
            end
         end
         PH_DUMMY: begin
            if (cnt_q == flsr_pkg::DISC_DUMMY_BITS - 5'h01) begin
               cnt_d = 5'h00;
               phase_d = PH_DISC;
            end
         end
         PH_STAT, PH_DISC, PH_SKIP: begin
         end
         default: phase_d = PH_SKIP;
      endcase
   end

   always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         phase_q <= PH_CMD;
         cnt_q <= 5'h00;
         sh_q <= 7'h00;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         busy_s1_q <= lnk.busy;
         busy_s2_q <= busy_s1_q;
      end
   end

   always_ff @(posedge spi_sclk_i) begin
      opc_q <= opc_d;
      tgl_q <= tgl_d;
   end

   assign lnk.opcode = opc_q;
   assign lnk.cmd_tgl = tgl_q;

   // ==========================================================
   // Read data, launched on the falling edge
   always_comb begin
      oe_d = 1'b0;
      miso_d = 1'b0;
      case (phase_q)
         PH_STAT: begin
            oe_d = 1'b1;
            // Status byte goes out high bit first; busy is the last bit
            miso_d = (cnt_q[2:0] == 3'h7) ? busy_s2_q : 1'b0;
         end
         PH_DISC: begin
            oe_d = 1'b1;
            // Low byte first, each byte high bit first
            miso_d = flsr_pkg::DISC_WORD[{cnt_q[4:3], ~cnt_q[2:0]}];
         end
         default: begin
         end
      endcase
   end

   always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else begin
         spi_miso_o <= miso_d;
         spi_miso_oe_o <= oe_d;
      end
   end

   // ==========================================================
   // Checks
   chk_status_busy_bit: assert property (
      @(posedge spi_sclk_i) disable iff (spi_cs_n_i)
      (phase_q == PH_STAT && cnt_q[2:0] == 3'h7)
      |-> (spi_miso_oe_o && spi_miso_o == busy_s2_q))
      else $error("status busy bit not driven");
   chk_disc_first_bit: assert property (
      @(posedge spi_sclk_i) disable iff (spi_cs_n_i)
      (phase_q == PH_DISC && cnt_q == 5'h00)
      |-> (spi_miso_oe_o && spi_miso_o == flsr_pkg::DISC_WORD[7]))
      else $error("discovery word first bit wrong");
   chk_opcode_announce: assert property (
      @(posedge spi_sclk_i) disable iff (spi_cs_n_i)
      (phase_q == PH_CMD && cnt_q == 5'h07)
      |=> (tgl_q != $past(tgl_q)) && (opc_q[0] == $past(spi_mosi_i)))
      else $error("opcode not announced after eighth bit");
endmodule : flsr_spi_link

// *** verif/flsr_host_model.sv ***
// Host side model: a mode 0 serial controller sending one opcode a frame
// and gathering read data. Assumes the bench calls frame() one at a time.
`timescale 1ns/1ps
module flsr_host_model #(
   parameter real RESUME_GAP_NS = 128000.0
) (
   // Serial pins
   output logic spi_sclk_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o,
   input wire logic spi_miso_i,
   input wire logic spi_miso_oe_i
);
   // ==========================================================
   // State
   localparam real HALF_NS = 3.0;
   real last_resume_ns = -1.0e9;
   logic [31:0] rx_q;
   logic oe_seen;

   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
      rx_q = 32'h0;
      oe_seen = 1'b0;
   end

   // ==========================================================
   // One frame: opcode, filler bits, then read bits
   task automatic frame(input logic [7:0] op, input int fill, input int rd);
      int i;
      // A suspend too soon after a resume is the host's fault: hold off
      if (op == 8'h75 || op == 8'h85) begin
         while ($realtime - last_resume_ns < RESUME_GAP_NS) #100;
      end
      rx_q = 32'h0;
      oe_seen = 1'b1;
      spi_cs_n_o = 1'b0;
      for (i = 0; i < 8 + fill; i++) begin
         if (i < 8) begin
            spi_mosi_o = op[3'(7 - i)];
         end else begin
            spi_mosi_o = ~spi_mosi_o;
         end
         #HALF_NS spi_sclk_o = 1'b1;
         #HALF_NS spi_sclk_o = 1'b0;
      end
      for (i = 0; i < rd; i++) begin
         #HALF_NS spi_sclk_o = 1'b1;
         rx_q = {rx_q[30:0], spi_miso_i};
         oe_seen = oe_seen & spi_miso_oe_i;
         #HALF_NS spi_sclk_o = 1'b0;
      end
      #HALF_NS spi_cs_n_o = 1'b1;
      // Released line must not keep showing the last bit
      spi_mosi_o = ~spi_mosi_o;
      if (op == 8'h7a || op == 8'h8a) begin
         last_resume_ns = $realtime;
      end
      #20;
   endtask : frame
endmodule : flsr_host_model

// *** verif/flash_suspend_resume_control_test.sv ***
// Self-checking bench for the suspend and resume controller.
// Assumes the host model owns the serial pins; the bench owns the array side.
`timescale 1ns/1ps
module flash_suspend_resume_control_test;
   // ==========================================================
   // Signals and instances
   localparam int LAT = 20;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic sclk, cs_n, mosi, miso, miso_oe;
   logic erase_start_i = 1'b0;
   logic prog_start_i = 1'b0;
   logic array_done_i = 1'b0;
   logic array_halted_i = 1'b0;
   logic halt, busy, esusp, psusp;
   logic [3:0] outs;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;

   assign outs = {psusp, esusp, busy, halt};
   always #2 clk_i = ~clk_i;

   flsr_ctrl #(.SUSP_LAT_CYC(LAT)) u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
      .erase_start_i(erase_start_i), .prog_start_i(prog_start_i),
      .array_done_i(array_done_i), .array_halted_i(array_halted_i),
      .array_halt_o(halt), .operation_busy_flag_o(busy),
      .erase_suspended_o(esusp), .prog_suspended_o(psusp));

   flsr_host_model #(.RESUME_GAP_NS(4000.0)) u_host (
      .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
      .spi_miso_i(miso), .spi_miso_oe_i(miso_oe));

   // ==========================================================
   // Shared tasks
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic pulse(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask : pulse

   // Waits a bounded time for one status output, ends on a falling edge
   task automatic expect_bit(input string what, input int k, input logic v,
                             input int lim);
      int n;
      n = 0;
      @(negedge clk_i);
      while (outs[k] !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      check(what, 32'(outs[k]), 32'(v));
   endtask : expect_bit

   task automatic status_is(input logic exp);
      u_host.frame(8'h05, 0, 8);
      check("status byte", 32'(u_host.rx_q[7:0]), 32'({7'h00, exp}));
      check("status drive", 32'(u_host.oe_seen), 32'h1);
   endtask : status_is

   // ==========================================================
   // Scenarios
   task automatic stray_cmds();
      logic [7:0] ops [4] = '{8'h75, 8'h7a, 8'h85, 8'h8a};
      foreach (ops[i]) begin
         u_host.frame(ops[i], 0, 0);
         repeat (6) @(negedge clk_i);
         check("idle after stray command", 32'(outs), 32'h0);
      end
      pulse(erase_start_i);
      u_host.frame(8'h85, 0, 0);
      u_host.frame(8'h8a, 0, 0);
      repeat (6) @(negedge clk_i);
      check("erase ignores program cmds", 32'(outs), 32'h2);
      // Completion while still waiting for the array to pause ends the erase
      u_host.frame(8'h75, 0, 0);
      expect_bit("halt before done", 0, 1'b1, 8);
      pulse(array_done_i);
      check("idle after done", 32'(outs), 32'h0);
   endtask : stray_cmds

   task automatic erase_cycle();
      pulse(erase_start_i);
      check("busy on erase", 32'(busy), 32'h1);
      status_is(1'b1);
      u_host.frame(8'h75, 0, 0);
      expect_bit("erase halt", 0, 1'b1, 8);
      check("busy while halting", 32'(busy), 32'h1);
      // No start pulses while suspended: no nested erase, no program
      array_halted_i = 1'b1;
      expect_bit("erase suspended", 2, 1'b1, 4);
      check("ready when erase suspended", 32'(busy), 32'h0);
      status_is(1'b0);
      u_host.frame(8'h7a, 0, 0);
      expect_bit("erase resumed", 2, 1'b0, 8);
      check("halt released busy again", 32'(outs[1:0]), 32'h2);
      array_halted_i = 1'b0;
      u_host.frame(8'h75, 0, 0);
      expect_bit("second erase halt", 0, 1'b1, 8);
      // Array never pauses here, so only the latency bound ends the wait
      expect_bit("erase latency bound", 2, 1'b1, LAT + 2);
      check("ready at erase bound", 32'(busy), 32'h0);
      u_host.frame(8'h7a, 0, 0);
      expect_bit("second erase resume", 2, 1'b0, 8);
      pulse(array_done_i);
      check("done ends erase", 32'(busy), 32'h0);
   endtask : erase_cycle

   task automatic prog_cycle();
      pulse(prog_start_i);
      u_host.frame(8'h85, 0, 0);
      expect_bit("program halt", 0, 1'b1, 8);
      // Array never pauses here, so only the latency bound ends the wait
      expect_bit("program suspended", 3, 1'b1, LAT + 2);
      check("ready when program suspended", 32'(busy), 32'h0);
      // No erase and no second program while suspended
      u_host.frame(8'h8a, 0, 0);
      expect_bit("program resumed", 3, 1'b0, 8);
      check("busy on program resume", 32'(busy), 32'h1);
      u_host.frame(8'h85, 0, 0);
      expect_bit("second program halt", 0, 1'b1, 8);
      array_halted_i = 1'b1;
      expect_bit("second program suspend", 3, 1'b1, 4);
      u_host.frame(8'h8a, 0, 0);
      expect_bit("second program resume", 3, 1'b0, 8);
      array_halted_i = 1'b0;
      pulse(array_done_i);
      check("done ends program", 32'(busy), 32'h0);
   endtask : prog_cycle

   task automatic disc_read();
      logic [31:0] w;
      u_host.frame(8'h5a, 32, 32);
      w = {u_host.rx_q[7:0], u_host.rx_q[15:8], u_host.rx_q[23:16],
           u_host.rx_q[31:24]};
      check("timing word", w, 32'h4418_83ec);
      check("read drive", 32'(u_host.oe_seen), 32'h1);
      check("erase latency count", 32'(w[28:24]), 32'h4);
      check("erase resume gap", 32'(w[23:20]), 32'h1);
      check("program latency unit", 32'(w[19:18]), 32'h2);
      check("program latency count", 32'(w[17:13]), 32'h4);
      check("program resume gap", 32'(w[12:9]), 32'h1);
      check("erase suspend limits", 32'(w[7:4]), 32'he);
      check("program suspend limits", 32'(w[3:0]), 32'hc);
   endtask : disc_read

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(negedge clk_i);
      srst_i = 1'b0;
      check("outputs after reset", 32'(outs), 32'h0);
      status_is(1'b0);
      stray_cmds();
      erase_cycle();
      prog_cycle();
      disc_read();
      complete_run();
   end
endmodule : flash_suspend_resume_control_test
